// ==== hw/idr_pkg.sv ====
package idr_pkg;

  // task-file offsets
  localparam logic [2:0] OFF_DATA = 3'h0;
  localparam logic [2:0] OFF_ERR = 3'h1;
  localparam logic [2:0] OFF_SCNT = 3'h2;
  localparam logic [2:0] OFF_DRVHD = 3'h6;
  localparam logic [2:0] OFF_CMD = 3'h7;

  // command codes
  localparam logic [7:0] CMD_IDENTIFY = 8'hec;
  localparam logic [7:0] CMD_SETMULT = 8'hc6;

  // field positions and reset values
  localparam int DRV_BIT = 4;
  localparam logic DEV_DRIVE = 1'b0;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ERR_ABRT = 2;
  localparam logic [7:0] STAT_IDLE = 8'h50;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] MULT_ONE = 8'h01;

  // parameter block
  localparam logic [7:0] LAST_WORD = 8'hff;
  localparam logic [15:0] W0_CFG = 16'h044a;
  localparam logic [15:0] W1_CYL = 16'h01ef;
  localparam logic [15:0] W3_HEADS = 16'h0004;
  localparam logic [15:0] W4_BPT = 16'h0000;
  localparam logic [15:0] W5_BPS = 16'h0200;
  localparam logic [15:0] W6_SPT = 16'h0020;
  localparam logic [31:0] TOTAL_SECT = 32'h0000f780;
  localparam logic [15:0] W20_BUFTYPE = 16'h0001;
  localparam logic [15:0] W21_BUFSIZE = 16'h0001;
  localparam logic [15:0] W22_ECC = 16'h0004;
  localparam logic [15:0] W47_MULT = 16'h0001;
  localparam logic [15:0] W48_DWORD = 16'h0000;
  localparam logic [15:0] W49_CAPS = 16'h0f00;
  localparam logic [15:0] W51_PIO = 16'h0200;
  localparam logic [15:0] W52_SWDMA = 16'h0000;
  localparam logic [15:0] W53_VALID = 16'h0003;
  localparam logic [7:0] W59_HI = 8'h01;
  localparam logic [15:0] W64_APIO = 16'h0003;

  // text fields, values arbitrary
  localparam logic [159:0] SERIAL_STR = "        IDR000000001";
  localparam logic [63:0] FW_STR = "REV1.00 ";
  localparam logic [319:0] MODEL_STR = "IDR PARAMETER RESPONDER                 ";

  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } idr_bus_t;

  typedef struct packed {
    logic [15:0] cyl;
    logic [15:0] heads;
    logic [15:0] spt;
  } idr_geom_t;

  typedef enum logic [1:0] {
    IDR_IDLE = 2'b01,
    IDR_XFER = 2'b10
  } idr_state_t;

endpackage

// ==== hw/idr_seq.sv ====
`timescale 1ns/1ns
module idr_seq (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic stop,
  input wire logic take,
  // progress
  output logic active,
  output logic [7:0] idx,
  output logic done
);
  import idr_pkg::*;

  idr_state_t state_reg;
  logic [7:0] idx_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= IDR_IDLE;
    end else begin
      case (state_reg)
        IDR_IDLE: begin
          if (start) begin
            state_reg <= IDR_XFER;
          end
        end
        IDR_XFER: begin
          if (start) begin
            state_reg <= IDR_XFER;
          end else if (stop) begin
            state_reg <= IDR_IDLE;
          end else if (take && idx_reg == LAST_WORD) begin
            state_reg <= IDR_IDLE;
          end
        end
        default: begin
          state_reg <= IDR_IDLE;
        end
      endcase
    end
  end

  // a fresh identify always restarts at word 0
  always_ff @(posedge clk) begin
    if (rst) begin
      idx_reg <= 8'h00;
    end else if (start) begin
      idx_reg <= 8'h00;
    end else if (take && state_reg == IDR_XFER) begin
      idx_reg <= idx_reg + 8'h01;
    end
  end

  assign active = (state_reg == IDR_XFER);
  assign idx = idx_reg;
  assign done = active && take && (idx_reg == LAST_WORD) && !start && !stop;

endmodule

// ==== hw/idr_identify.sv ====
`timescale 1ns/1ns
// Behaviour
// - identify command ECh with matching drive bit prepares the 256-word block
// - block leaves as one 512-byte sector using the sector-read data-in handshake
// - reserved bits and words, including 2, 9, 50, 62-63, 65-255, read zero
// - word 0 reads 044Ah general configuration
// - words 1, 3, 6 give default cylinders 01EFh, heads 0004h, sectors 0020h
// - word 4 reads 0000h and word 5 reads 0200h
// - words 7-8 give total sectors 0000h, F780h, high half first
// - words 10-19 hold serial text, right aligned, space padded
// - words 20 and 21 both read 0001h
// - word 22 reads 0004h ECC bytes
// - words 23-26 hold firmware text, first character in high byte
// - words 27-46 hold model text, left aligned, space padded, high byte first
// - word 47 reads 0001h
// - words 48 and 52 read 0000h
// - word 49 reads 0F00h, DMA and LBA supported
// - word 51 reads 0200h legacy PIO mode
// - word 53 bit 0 set, words 54-58 valid
// - word 53 bit 1 set too, words 64-70 valid
// - words 54-56 current geometry, 57-58 current capacity low half first
// - word 59 reads 0100h by default
// - words 60-61 give total LBA sectors
// - word 64 reads 0003h
// - word 59 high byte 01h, low byte 01h after set multiple of one
module idr_identify (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // task-file port
  input wire idr_pkg::idr_bus_t bus,
  output logic [15:0] rdata,
  // current translation from the geometry logic
  input wire idr_pkg::idr_geom_t cur_geom,
  // handshake toward the shared read-sector logic
  output logic drq,
  output logic xfer_done
);
  import idr_pkg::*;

  logic [7:0] scnt_reg;
  logic [7:0] drvhd_reg;
  logic [7:0] mult_reg;
  logic abort_reg;
  logic [31:0] cap_reg;
  logic [47:0] cap_full;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [15:0] word_val;
  logic [7:0] status;
  logic [7:0] idx;
  logic [7:0] rel;
  logic cmd_wr;
  logic [7:0] cmd;
  logic drv_ok;
  logic id_start;
  logic stop;
  logic take;
  logic set_ok;
  logic set_bad;

  assign cmd_wr = bus.wr && (bus.addr == OFF_CMD);
  assign cmd = bus.wdata[7:0];
  // only the drive-select bit matters, head bits are ignored
  assign drv_ok = (drvhd_reg[DRV_BIT] == DEV_DRIVE);
  assign id_start = cmd_wr && (cmd == CMD_IDENTIFY) && drv_ok;
  // any other command ends a half-read block
  assign stop = cmd_wr && !id_start;
  assign take = bus.rd && (bus.addr == OFF_DATA) && drq;
  assign set_ok = cmd_wr && (cmd == CMD_SETMULT) && (scnt_reg <= MULT_ONE);
  assign set_bad = cmd_wr && (cmd == CMD_SETMULT) && (scnt_reg > MULT_ONE);

  idr_seq u_seq (
    .clk(clk),
    .rst(rst),
    .start(id_start),
    .stop(stop),
    .take(take),
    .active(drq),
    .idx(idx),
    .done(xfer_done)
  );

  // task-file registers that feed this block
  always_ff @(posedge clk) begin
    if (rst) begin
      scnt_reg <= REG_RST;
    end else if (bus.wr && bus.addr == OFF_SCNT) begin
      scnt_reg <= bus.wdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      drvhd_reg <= REG_RST;
    end else if (bus.wr && bus.addr == OFF_DRVHD) begin
      drvhd_reg <= bus.wdata[7:0];
    end
  end

  // only one or zero sectors per block are accepted
  always_ff @(posedge clk) begin
    if (rst) begin
      mult_reg <= REG_RST;
    end else if (set_ok) begin
      mult_reg <= scnt_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      abort_reg <= 1'b0;
    end else if (cmd_wr) begin
      abort_reg <= set_bad;
    end
  end

  // registered so the triple product stays off the read path
  assign cap_full = 48'(cur_geom.cyl) * 48'(cur_geom.heads) * 48'(cur_geom.spt);

  always_ff @(posedge clk) begin
    if (rst) begin
      cap_reg <= 32'h0000_0000;
    end else begin
      cap_reg <= cap_full[31:0];
    end
  end

  // parameter word at the current index; unlisted words fall to zero
  always_comb begin
    word_val = 16'h0000;
    rel = 8'h00;
    case (idx)
      8'd0: word_val = W0_CFG;
      8'd1: word_val = W1_CYL;
      8'd3: word_val = W3_HEADS;
      8'd4: word_val = W4_BPT;
      8'd5: word_val = W5_BPS;
      8'd6: word_val = W6_SPT;
      8'd7: word_val = TOTAL_SECT[31:16];
      8'd8: word_val = TOTAL_SECT[15:0];
      8'd20: word_val = W20_BUFTYPE;
      8'd21: word_val = W21_BUFSIZE;
      8'd22: word_val = W22_ECC;
      8'd47: word_val = W47_MULT;
      8'd48: word_val = W48_DWORD;
      8'd49: word_val = W49_CAPS;
      8'd51: word_val = W51_PIO;
      8'd52: word_val = W52_SWDMA;
      8'd53: word_val = W53_VALID;
      8'd54: word_val = cur_geom.cyl;
      8'd55: word_val = cur_geom.heads;
      8'd56: word_val = cur_geom.spt;
      8'd57: word_val = cap_reg[15:0];
      8'd58: word_val = cap_reg[31:16];
      8'd59: word_val = {W59_HI, mult_reg};
      8'd60: word_val = TOTAL_SECT[15:0];
      8'd61: word_val = TOTAL_SECT[31:16];
      8'd64: word_val = W64_APIO;
      default: begin
        // text fields, first character in the high byte
        if (idx >= 8'd10 && idx <= 8'd19) begin
          rel = idx - 8'd10;
          word_val = 16'(SERIAL_STR >> (16 * (9 - int'(rel))));
        end else if (idx >= 8'd23 && idx <= 8'd26) begin
          rel = idx - 8'd23;
          word_val = 16'(FW_STR >> (16 * (3 - int'(rel))));
        end else if (idx >= 8'd27 && idx <= 8'd46) begin
          rel = idx - 8'd27;
          word_val = 16'(MODEL_STR >> (16 * (19 - int'(rel))));
        end
      end
    endcase
  end

  always_comb begin
    status = STAT_IDLE;
    status[ST_DRQ] = drq;
    status[ST_ERR] = abort_reg;
  end

  // read answer, one cycle after the strobe and only then
  always_comb begin
    rdata_next = 16'h0000;
    if (bus.rd) begin
      case (bus.addr)
        OFF_DATA: rdata_next = drq ? word_val : 16'h0000;
        OFF_ERR: rdata_next = {13'h0000, abort_reg, 2'b00};
        OFF_SCNT: rdata_next = {8'h00, scnt_reg};
        OFF_DRVHD: rdata_next = {8'h00, drvhd_reg};
        OFF_CMD: rdata_next = {8'h00, status};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 16'h0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_identify_start: assert property (
    id_start |=> drq && idx == 8'h00
  ) else $error("identify did not open the block at word 0");

  a_wrong_drive: assert property (
    cmd_wr && cmd == CMD_IDENTIFY && !drv_ok && !drq |=> !drq
  ) else $error("identify for the other drive was taken");

  a_block_end: assert property (
    take && idx == LAST_WORD && !cmd_wr |=> !drq && !take
  ) else $error("data request outlived word 255");

  a_word_order: assert property (
    take && idx != LAST_WORD && !cmd_wr |=> drq && idx == $past(idx) + 8'h01
  ) else $error("words did not advance by one");

  a_reserved_zero: assert property (
    take && ((idx >= 8'd62 && idx != 8'd64) || idx == 8'd2 || idx == 8'd9 || idx == 8'd50)
      |=> rdata == 16'h0000
  ) else $error("reserved word not zero");

  a_word0_config: assert property (
    take && idx == 8'd0 |=> rdata == 16'h044a
  ) else $error("word 0 wrong");

  a_default_geom: assert property (
    take && (idx == 8'd1 || idx == 8'd3 || idx == 8'd6)
      |=> rdata == ($past(idx) == 8'd1 ? 16'h01ef :
                    $past(idx) == 8'd3 ? 16'h0004 : 16'h0020)
  ) else $error("default cylinders, heads or sectors wrong");

  a_sector_bytes: assert property (
    take && idx == 8'd5 |=> rdata == 16'h0200
  ) else $error("word 5 wrong");

  a_total_sect: assert property (
    take && (idx == 8'd7 || idx == 8'd8)
      |=> rdata == ($past(idx) == 8'd7 ? 16'h0000 : 16'hf780)
  ) else $error("total sectors wrong");

  a_serial_text: assert property (
    take && idx == 8'd10 |=> rdata == SERIAL_STR[159:144]
  ) else $error("serial first word wrong");

  a_buffer_words: assert property (
    take && (idx == 8'd20 || idx == 8'd21) |=> rdata == 16'h0001
  ) else $error("buffer words wrong");

  a_ecc_count: assert property (
    take && idx == 8'd22 |=> rdata == 16'h0004
  ) else $error("ecc count wrong");

  a_fw_text: assert property (
    take && idx == 8'd23 |=> rdata == FW_STR[63:48]
  ) else $error("firmware first word wrong");

  a_model_text: assert property (
    take && idx == 8'd46 |=> rdata == MODEL_STR[15:0]
  ) else $error("model last word wrong");

  a_fixed_caps: assert property (
    take && (idx == 8'd47 || idx == 8'd49 || idx == 8'd51)
      |=> rdata == ($past(idx) == 8'd47 ? 16'h0001 :
                    $past(idx) == 8'd49 ? 16'h0f00 : 16'h0200)
  ) else $error("capability word wrong");

  a_no_dword: assert property (
    take && (idx == 8'd48 || idx == 8'd52) |=> rdata == 16'h0000
  ) else $error("word 48 or 52 not zero");

  a_valid_bits: assert property (
    take && idx == 8'd53 |=> rdata[1:0] == 2'b11
  ) else $error("word 53 valid bits clear");

  a_cur_capacity: assert property (
    take && idx == 8'd57 |=> rdata == $past(cap_reg[15:0])
  ) else $error("current capacity low half wrong");

  a_mult_word: assert property (
    take && idx == 8'd59 |=> rdata == {8'h01, $past(mult_reg)}
  ) else $error("word 59 wrong");

  a_set_mult: assert property (
    set_ok && scnt_reg == 8'h01 |=> mult_reg == 8'h01
  ) else $error("set multiple of one not kept");

  a_lba_total: assert property (
    take && idx == 8'd60 |=> rdata == 16'hf780
  ) else $error("lba total low half wrong");

  a_adv_pio: assert property (
    take && idx == 8'd64 |=> rdata == 16'h0003
  ) else $error("word 64 wrong");

  a_read_window: assert property (
    !bus.rd |=> rdata == 16'h0000
  ) else $error("read data stood outside its cycle");

  a_idle_data: assert property (
    bus.rd && bus.addr == OFF_DATA && !drq |=> rdata == 16'h0000 && !drq
  ) else $error("data read without request returned data");

  a_other_cmd: assert property (
    cmd_wr && !id_start |=> !drq
  ) else $error("request survived another command");

  a_done_pulse: assert property (
    xfer_done |-> take && idx == LAST_WORD
  ) else $error("end pulse outside the last word read");

  a_word_hold: assert property (
    drq && !take && !cmd_wr |=> drq && $stable(idx)
  ) else $error("word index moved without a read");

  a_set_refused: assert property (
    cmd_wr && cmd == CMD_SETMULT && scnt_reg > 8'h01 |=> $stable(mult_reg)
  ) else $error("refused multiple setting was kept");

  a_mult_range: assert property (
    mult_reg <= 8'h01
  ) else $error("multiple setting out of range");

  a_abort_set: assert property (
    set_bad |=> abort_reg
  ) else $error("refused multiple setting not flagged");

  a_status_read: assert property (
    bus.rd && bus.addr == OFF_CMD |=> rdata[15:8] == 8'h00 && rdata[ST_DRQ] == $past(drq)
  ) else $error("status read does not show the request");

  c_identify: cover property (id_start ##1 drq);
  c_full_block: cover property (xfer_done);
  c_mult_then_id: cover property (set_ok && scnt_reg == 8'h01 ##[1:20] id_start);
  c_restart: cover property (drq && id_start);

endmodule

// ==== bench/idr_host.sv ====
`timescale 1ns/1ns
module idr_host (
  // clock
  input wire logic clk,
  // task-file port
  output idr_pkg::idr_bus_t bus,
  input wire logic [15:0] rdata,
  // observed end of block
  input wire logic done
);
  import idr_pkg::*;

  initial begin
    bus = '0;
  end

  // released lines show the inverse, so a stale value never passes
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  // one word per strobe, answer taken in the following cycle
  task automatic rd(input logic [2:0] a, output logic [15:0] d, output logic dn);
    @(posedge clk);
    bus <= '{addr: a, wdata: ~bus.wdata, wr: 1'b0, rd: 1'b1};
    @(negedge clk);
    dn = done;
    @(posedge clk);
    bus <= '{addr: ~a, wdata: ~bus.wdata, wr: 1'b0, rd: 1'b0};
    @(negedge clk);
    d = rdata;
  endtask
endmodule

// ==== bench/ata_identify_responder_test.sv ====
`timescale 1ns/1ns
module ata_identify_responder_test;
  import idr_pkg::*;

  logic clk;
  logic rst;
  idr_bus_t bus;
  logic [15:0] rdata;
  idr_geom_t geom;
  logic drq;
  logic xfer_done;
  logic [7:0] mult;
  logic [15:0] d;
  logic dn;
  int err_count = 0;
  int check_count = 0;

  idr_identify uut (
    .clk(clk),
    .rst(rst),
    .bus(bus),
    .rdata(rdata),
    .cur_geom(geom),
    .drq(drq),
    .xfer_done(xfer_done)
  );

  idr_host host (
    .clk(clk),
    .bus(bus),
    .rdata(rdata),
    .done(xfer_done)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [15:0] exp_word(input int k);
    logic [31:0] cap;
    cap = geom.cyl * geom.heads * geom.spt;
    case (k)
      0: return 16'h044a;
      1: return 16'h01ef;
      3: return 16'h0004;
      5: return 16'h0200;
      6: return 16'h0020;
      8: return 16'hf780;
      20, 21: return 16'h0001;
      22: return 16'h0004;
      47: return 16'h0001;
      49: return 16'h0f00;
      51: return 16'h0200;
      53: return 16'h0003;
      54: return geom.cyl;
      55: return geom.heads;
      56: return geom.spt;
      57: return cap[15:0];
      58: return cap[31:16];
      59: return {8'h01, mult};
      60: return 16'hf780;
      64: return 16'h0003;
      default: begin
        if (k >= 10 && k <= 19) begin
          return SERIAL_STR[159-16*(k-10) -: 16];
        end
        if (k >= 23 && k <= 26) begin
          return FW_STR[63-16*(k-23) -: 16];
        end
        if (k >= 27 && k <= 46) begin
          return MODEL_STR[319-16*(k-27) -: 16];
        end
        return 16'h0000;
      end
    endcase
  endfunction

  task automatic read_words(input int n);
    for (int k = 0; k < n; k++) begin
      host.rd(OFF_DATA, d, dn);
      chk("block word", d, exp_word(k));
      chk("end pulse", {15'h0, dn}, {15'h0, k == 255});
    end
  endtask

  task automatic read_block();
    read_words(256);
    @(negedge clk);
    chk("drq after block", {15'h0, drq}, 16'h0000);
  endtask

  // head and upper bits set: only the drive bit may matter
  task automatic identify();
    host.wr(OFF_DRVHD, 16'h00ef);
    host.wr(OFF_CMD, 16'h00ec);
    @(negedge clk);
    chk("drq after identify", {15'h0, drq}, 16'h0001);
    host.rd(OFF_CMD, d, dn);
    chk("status in block", d, 16'h0058);
  endtask

  task automatic set_mult(input logic [15:0] cnt);
    host.wr(OFF_SCNT, cnt);
    host.wr(OFF_CMD, 16'h00c6);
  endtask

  initial begin
    rst = 1'b1;
    mult = 8'h00;
    geom = '{cyl: 16'h0100, heads: 16'h0010, spt: 16'h003f};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    host.rd(OFF_CMD, d, dn);
    chk("status idle", d, 16'h0050);
    host.rd(OFF_DATA, d, dn);
    chk("data without request", d, 16'h0000);
    for (int a = 3; a <= 5; a++) begin
      host.rd(3'(a), d, dn);
      chk("unused register", d, 16'h0000);
    end
    host.wr(OFF_DRVHD, 16'h0010);
    host.wr(OFF_CMD, 16'h00ec);
    @(negedge clk);
    chk("other drive ignored", {15'h0, drq}, 16'h0000);
    identify();
    read_block();
    @(posedge clk);
    geom <= '{cyl: 16'h01ef, heads: 16'h0004, spt: 16'h0020};
    set_mult(16'h0001);
    mult = 8'h01;
    identify();
    read_block();
    set_mult(16'h0002);
    host.rd(OFF_ERR, d, dn);
    chk("abort flag", d, 16'h0004);
    host.rd(OFF_CMD, d, dn);
    chk("status after abort", d, 16'h0051);
    identify();
    read_words(3);
    host.wr(OFF_CMD, 16'h00e5);
    @(negedge clk);
    chk("drq after other command", {15'h0, drq}, 16'h0000);
    // a second identify mid-block must start over at word 0
    identify();
    read_words(3);
    identify();
    read_block();
    // reset in mid-block drops the request and the multiple setting
    identify();
    read_words(3);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    mult = 8'h00;
    @(negedge clk);
    chk("drq after reset", {15'h0, drq}, 16'h0000);
    host.rd(OFF_CMD, d, dn);
    chk("status after reset", d, 16'h0050);
    identify();
    read_words(60);
    // a count of zero takes the setting back to none
    set_mult(16'h0001);
    set_mult(16'h0000);
    identify();
    read_words(60);
    stop_test();
  end

  // about four blocks of reads is the longest expected run
  initial begin
    #(20000 * 50);
    err_count++;
    stop_test();
  end
endmodule
